// File: include/cpr_pkg.sv
// cpr_pkg: constants and carrier types for the core pointer registers
// assumes an 8-bit special-function register space reached by direct address
package cpr_pkg;
	// special-function addresses
	localparam logic [7:0] CPR_ADDR_STACK_POINTER = 8'h81;
	localparam logic [7:0] CPR_ADDR_DATA_POINTER_LOW = 8'h82;
	// no offset is printed for the high byte; next slot chosen
	localparam logic [7:0] CPR_ADDR_DATA_POINTER_HIGH = 8'h83;
	// reset values
	localparam logic [7:0] CPR_RST_STACK_POINTER = 8'h07;
	localparam logic [7:0] CPR_RST_DATA_POINTER_LOW = 8'h00;
	localparam logic [7:0] CPR_RST_DATA_POINTER_HIGH = 8'h00;
	localparam logic [7:0] CPR_READ_UNMAPPED = 8'h00;
	localparam logic [7:0] CPR_STEP = 8'h01;
	localparam int CPR_STACK_DEPTH = 256;

	// special-function register access from the core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cpr_sfr_req_s;

	// stack operation request
	typedef struct packed {
		logic push;
		logic pop;
		logic [7:0] data;
	} cpr_stack_req_s;

	// module state
	typedef struct packed {
		logic [7:0] stack_pointer;
		logic [7:0] data_pointer_low;
		logic [7:0] data_pointer_high;
		logic [7:0] sfr_rdata;
		logic pop_valid;
	} cpr_state_s;
endpackage : cpr_pkg

// File: rtl/cpr_stack_ram.sv
// cpr_stack_ram: internal data memory holding the stack
// single clock; one write and one registered read per cycle
`timescale 1ns/1ps
`default_nettype none
module cpr_stack_ram
	import cpr_pkg::*;
#(
	parameter int DEPTH = CPR_STACK_DEPTH,
	parameter int AW = 8
)
(
	// clock
	input wire logic clk,
	// write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// read side
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	// no reset on the array; contents are undefined until written
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		if (re)
		begin
			rdata <= mem[raddr];
		end
	end
endmodule : cpr_stack_ram
`default_nettype wire

// File: rtl/cpr_core_pointers.sv
// cpr_core_pointers: data pointer and stack pointer of the core
// assumes core issues single-cycle sfr, stack and external-move strobes
// Summary of operation
// - low pointer byte at 0x82, reset zero
// - high pointer byte, reset zero, forms word
// - stack pointer names top of stack
// - push increments pointer, then writes byte
// - stack pointer at 0x81, resets to 0x07
// - stack spans full 256-byte memory
// - external move drives full pointer word
`timescale 1ns/1ps
`default_nettype none
module cpr_core_pointers
	import cpr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// special-function register access
	input wire cpr_sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// stack operations
	input wire cpr_stack_req_s stack_req,
	output logic [7:0] pop_data,
	output logic pop_valid,
	// external data move
	input wire logic external_data_move,
	output logic [15:0] data_pointer_word,
	output logic [15:0] ext_addr,
	output logic ext_addr_valid,
	// pointer visibility
	output logic [7:0] stack_pointer
);
	cpr_state_s state_r;
	cpr_state_s state_nxt;
	logic push_go;
	logic pop_go;
	logic [7:0] stack_pointer_inc;

	// push wins if both arrive together, pops are dropped then
	assign push_go = stack_req.push;
	assign pop_go = stack_req.pop && !stack_req.push;
	assign stack_pointer_inc = state_r.stack_pointer + CPR_STEP;

	// eight-bit pointer wraps over whole memory
	cpr_stack_ram #(
		.DEPTH(CPR_STACK_DEPTH),
		.AW(8)
	) u_ram (
		.clk(clk),
		.we(push_go),
		.waddr(stack_pointer_inc),
		.wdata(stack_req.data),
		.re(pop_go),
		.raddr(state_r.stack_pointer),
		.rdata(pop_data)
	);

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.pop_valid = pop_go;
		state_nxt.sfr_rdata = CPR_READ_UNMAPPED;
		if (sfr_req.rd)
		begin
			case (sfr_req.addr)
				CPR_ADDR_STACK_POINTER: state_nxt.sfr_rdata = state_r.stack_pointer;
				CPR_ADDR_DATA_POINTER_LOW: state_nxt.sfr_rdata = state_r.data_pointer_low;
				CPR_ADDR_DATA_POINTER_HIGH: state_nxt.sfr_rdata = state_r.data_pointer_high;
				default: state_nxt.sfr_rdata = CPR_READ_UNMAPPED;
			endcase
		end
		if (sfr_req.wr)
		begin
			case (sfr_req.addr)
				CPR_ADDR_STACK_POINTER: state_nxt.stack_pointer = sfr_req.wdata;
				CPR_ADDR_DATA_POINTER_LOW: state_nxt.data_pointer_low = sfr_req.wdata;
				CPR_ADDR_DATA_POINTER_HIGH: state_nxt.data_pointer_high = sfr_req.wdata;
				default: state_nxt.data_pointer_low = state_r.data_pointer_low;
			endcase
		end
		// stack motion overrides a same-cycle pointer write
		if (push_go)
		begin
			state_nxt.stack_pointer = stack_pointer_inc;
		end
		else if (pop_go)
		begin
			state_nxt.stack_pointer = state_r.stack_pointer - CPR_STEP;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r.stack_pointer <= CPR_RST_STACK_POINTER;
			state_r.data_pointer_low <= CPR_RST_DATA_POINTER_LOW;
			state_r.data_pointer_high <= CPR_RST_DATA_POINTER_HIGH;
			state_r.sfr_rdata <= CPR_READ_UNMAPPED;
			state_r.pop_valid <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign sfr_hit = (sfr_req.addr == CPR_ADDR_STACK_POINTER)
		|| (sfr_req.addr == CPR_ADDR_DATA_POINTER_LOW)
		|| (sfr_req.addr == CPR_ADDR_DATA_POINTER_HIGH);
	assign sfr_rdata = state_r.sfr_rdata;
	assign pop_valid = state_r.pop_valid;
	assign stack_pointer = state_r.stack_pointer;
	assign data_pointer_word = {state_r.data_pointer_high, state_r.data_pointer_low};
	assign ext_addr = data_pointer_word;
	assign ext_addr_valid = external_data_move;
endmodule : cpr_core_pointers
`default_nettype wire

// File: verif/cpr_core_pointers_sva.sv
// pointer port assertions
// bound below into the design
`timescale 1ns/1ps
`default_nettype none
module cpr_core_pointers_sva
	import cpr_pkg::*;
(
	// all inputs
	input wire logic clk,
	input wire logic rst,
	input wire cpr_sfr_req_s sfr_req,
	input wire cpr_stack_req_s stack_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic pop_valid,
	input wire logic [15:0] data_pointer_word,
	input wire logic [7:0] stack_pointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire [7:0] stk_ptr = stack_pointer;
	wire pu = stack_req.push;
	a_push_inc: assert property (pu |=>
		stk_ptr == $past(stk_ptr) + 8'h01) else $error("push");
	a_pop_dec: assert property (stack_req.pop && !pu |=> pop_valid &&
		stk_ptr == $past(stk_ptr) - 8'h01) else $error("pop");
	a_stack_wrap: assert property (pu && stk_ptr == 8'hff |=>
		stk_ptr == 8'h00) else $error("wrap");
	a_low_wr: assert property (sfr_req.wr && sfr_req.addr == 8'h82 |=>
		data_pointer_word[7:0] == $past(sfr_req.wdata)) else $error("lo");
	a_high_wr: assert property (sfr_req.wr &&
		sfr_req.addr == CPR_ADDR_DATA_POINTER_HIGH |=>
		data_pointer_word[15:8] == $past(sfr_req.wdata)) else $error("hi");
	// stack motion overrides the write, so only quiet cycles are checked
	a_ptr_write: assert property (sfr_req.wr && !pu && !stack_req.pop &&
		sfr_req.addr == CPR_ADDR_STACK_POINTER |=>
		stk_ptr == $past(sfr_req.wdata)) else $error("ptr write");
	a_ptr_read: assert property (sfr_req.rd &&
		sfr_req.addr == CPR_ADDR_STACK_POINTER |=>
		sfr_rdata == $past(stk_ptr)) else $error("ptr read");
	a_pop_pulse: assert property (pop_valid |->
		$past(stack_req.pop && !pu)) else $error("pulse");
endmodule : cpr_core_pointers_sva
bind cpr_core_pointers cpr_core_pointers_sva chk_u (
	.clk(clk),
	.rst(rst),
	.sfr_req(sfr_req),
	.stack_req(stack_req),
	.sfr_rdata(sfr_rdata),
	.pop_valid(pop_valid),
	.data_pointer_word(data_pointer_word),
	.stack_pointer(stack_pointer)
);
`default_nettype wire

// File: verif/cpr_core_pointers_test.sv
// pointer register bench
// drives all inputs itself
`timescale 1ns/1ps
`default_nettype none
module cpr_core_pointers_test
	import cpr_pkg::*;
;
	logic clk, rst, external_data_move, pop_valid, ext_addr_valid, sfr_hit;
	cpr_sfr_req_s sfr_req;
	cpr_stack_req_s stack_req;
	logic [7:0] sfr_rdata, pop_data, stack_pointer;
	logic [15:0] data_pointer_word, ext_addr;
	int error_cnt, cmp_count;
	logic [23:0] rows [3] = '{24'h815a5a, 24'h823434, 24'h90ff00};
	cpr_core_pointers dut_u (
		.clk(clk),
		.rst(rst),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit),
		.stack_req(stack_req),
		.pop_data(pop_data),
		.pop_valid(pop_valid),
		.external_data_move(external_data_move),
		.data_pointer_word(data_pointer_word),
		.ext_addr(ext_addr),
		.ext_addr_valid(ext_addr_valid),
		.stack_pointer(stack_pointer)
	);
	task chk(input logic [15:0] g, e);
		cmp_count++;
		if (g !== e)
			$display("ERROR %0t bad %h", $time, g);
		error_cnt += int'(g !== e);
	endtask : chk
	task op(input cpr_sfr_req_s s, input cpr_stack_req_s k);
		@(posedge clk);
		{sfr_req, stack_req} <= {s, k};
		@(posedge clk);
		{sfr_req, stack_req} <= '0;
		#1;
	endtask : op
	task report_and_stop;
		$display("cmp %0d err %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		{sfr_req, stack_req} = '0;
		{rst, external_data_move} = 2'h3;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		op(18'h28100, '0);
		chk(sfr_rdata, 8'h07);
		$display("reset done");
		foreach (rows[i])
		begin
			op({2'b01, rows[i][23:8]}, '0);
			op({2'b10, rows[i][23:16], 8'h00}, '0);
			chk(sfr_rdata, rows[i][7:0]);
		end
		op(18'h18312, '0);
		chk(ext_addr, 16'h1234);
		chk(data_pointer_word, 16'h1234);
		$display("rows done");
		op(18'h181ff, '0);
		op('0, 10'h2bb);
		chk(stack_pointer, 8'h00);
		op('0, 10'h100);
		chk(pop_data, 8'hbb);
		chk(stack_pointer, 8'hff);
		chk(pop_valid, 1'b1);
		$display("stack done");
		// second reset in mid-run must restore every register except the memory read data pop_data
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(stack_pointer, 8'h07);
		chk(data_pointer_word, 16'h0000);
		chk({pop_valid, sfr_rdata}, 9'h000);
		$display("mid reset done");
		// push and pop together: pop is dropped
		op('0, 10'h3aa);
		chk({pop_valid, stack_pointer}, 9'h008);
		// memory is not reset, so only a write at 0x08 gives this byte
		op('0, 10'h100);
		chk({pop_valid, pop_data}, 9'h1aa);
		chk(stack_pointer, 8'h07);
		// combinational outputs looked at while the request stands
		@(posedge clk);
		sfr_req <= 18'h28300;
		external_data_move <= 1'b0;
		#1;
		chk({sfr_hit, ext_addr_valid}, 2'b10);
		@(posedge clk);
		sfr_req <= 18'h29000;
		external_data_move <= 1'b1;
		#1;
		chk({sfr_hit, ext_addr_valid}, 2'b01);
		@(posedge clk);
		sfr_req <= '0;
		#1;
		chk(sfr_rdata, 8'h00);
		$display("awkward done");
		report_and_stop();
	end
endmodule : cpr_core_pointers_test
`default_nettype wire
